// file: logic/kws_keypad_status.v
// Keypad wakeup configuration and status registers behind an APB slave.
// Assumes scan, debounce and three-key matching live outside and report by pulses and levels.
// Functional notes
// RULE1: Wakeup enable bit gates keypad wakeup
// RULE2: Column mask selects waking columns
// RULE3: Row field selects waking row
// RULE4: Row field binary with decoder, else one-hot
// RULE5: Key change sets interrupt flag
// RULE6: Three keys interrupt when reset disabled
// RULE7: Status read clears interrupt flag
// RULE8: Record flag set after three-key reset
// RULE9: Status read clears reset record flag
// RULE10: Wakeup flag set when keypad woke chip
// RULE11: Three-key detected flag when combo pressed
// RULE12: Both registers reset to zero
// RULE13: Lowest scan address reported as key zero
// RULE14: Two-key and one-key flags with addresses
// RULE15: Combo only when enabled; interrupt or reset
// RULE16: Reserved bits read zero, writes ignored
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`include "kws_consts.vh"

module kws_keypad_status #(
	parameter ROW_W = 4,
	parameter COL_W = 3,
	parameter COLS = 8,
	parameter ROWS = 16
) (
	input wire clock_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire scan_done_i,
	input wire key_change_i,
	input wire [1:0] key_count_i,
	input wire [ROW_W-1:0] key_a_row_i,
	input wire [COL_W-1:0] key_a_col_i,
	input wire [ROW_W-1:0] key_b_row_i,
	input wire [COL_W-1:0] key_b_col_i,
	input wire combo_detect_enable_i,
	input wire combo_reset_enable_i,
	input wire combo_match_i,
	input wire reset_by_combo_i,
	input wire powerdown_i,
	input wire decoder_mode_i,
	input wire [ROW_W-1:0] probe_row_i,
	input wire [COLS-1:0] col_sense_i,
	output wire keypad_irq_o,
	output wire combo_reset_req_o,
	output wire wakeup_o
);

	// ==========================================================
	// Row selection decode
	function row_selected;
		input [ROW_W-1:0] sel;
		input decoded;
		input integer row;
		begin
			// Binary row number with a decoder, one bit per row for rows 0 to 3 without
			if (decoded) begin
				row_selected = (sel == row[ROW_W-1:0]); // RULE4
			end else if (row < `KWS_ONEHOT_ROWS) begin
				row_selected = sel[row]; // RULE4
			end else begin
				row_selected = 1'b0;
			end
		end
	endfunction

	// Full-word address match; every other address is unmapped
	function addr_is;
		input [31:0] addr;
		input [31:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// ==========================================================
	// State
	reg [31:0] cfg_r;
	reg [31:0] prdata_r;
	reg pready_r;
	reg pslverr_r;
	reg int_r;
	reg trst_r;
	reg pdw_r;
	reg combo_r;
	reg two_r;
	reg one_r;
	reg [ROW_W-1:0] k0_row_r;
	reg [COL_W-1:0] k0_col_r;
	reg [ROW_W-1:0] k1_row_r;
	reg [COL_W-1:0] k1_col_r;
	reg boot_r;
	reg match_prev_r;
	reg irq_r;
	reg rst_req_r;
	reg wake_r;
	reg int_nxt;
	reg trst_nxt;
	reg pdw_nxt;
	reg combo_nxt;

	// ==========================================================
	// APB decode
	wire setup;
	wire access_done;
	wire hit_cfg;
	wire hit_status;
	wire wr_cfg;
	wire rd_status;
	wire [31:0] status_word;

	assign setup = psel_i && !penable_i;
	// A transfer completes on its access edge; no further wait states
	assign access_done = psel_i && penable_i && pready_r;
	assign hit_cfg = addr_is(paddr_i, `KWS_ADDR_WAKE_CFG);
	assign hit_status = addr_is(paddr_i, `KWS_ADDR_STATUS);
	assign wr_cfg = access_done && pwrite_i && hit_cfg;
	assign rd_status = access_done && !pwrite_i && hit_status;

	// ==========================================================
	// Wakeup decision
	wire wake_en;
	wire [COLS-1:0] col_mask;
	wire [ROW_W-1:0] row_sel;
	wire [ROWS-1:0] row_map;
	wire [COLS-1:0] col_hit;
	wire row_ok;
	wire wake_hit;

	assign wake_en = cfg_r[`KWS_CFG_WAKE_EN];
	assign col_mask = cfg_r[`KWS_CFG_COL_HI:`KWS_CFG_COL_LO];
	assign row_sel = cfg_r[`KWS_CFG_ROW_HI:`KWS_CFG_ROW_LO];
	assign row_ok = row_map[probe_row_i]; // RULE3
	// A level condition: wakeup_o stays up while a masked key is held in power down
	assign wake_hit = powerdown_i && wake_en && row_ok && |col_hit; // RULE1 RULE2

	// ==========================================================
	// Row decode for every matrix row
	genvar row_g;
	genvar col_g;

	generate
		for (row_g = 0; row_g < ROWS; row_g = row_g + 1) begin : g_row
			assign row_map[row_g] = row_selected(row_sel, decoder_mode_i, row_g); // RULE4
		end
	endgenerate

	// ==========================================================
	// Column mask against the sensed columns
	generate
		for (col_g = 0; col_g < COLS; col_g = col_g + 1) begin : g_col
			assign col_hit[col_g] = col_mask[col_g] && col_sense_i[col_g]; // RULE2
		end
	endgenerate

	// ==========================================================
	// Three-key events
	wire combo_rise;
	wire combo_irq;
	wire combo_rst;

	assign combo_rise = combo_detect_enable_i && combo_match_i && !match_prev_r; // RULE15
	assign combo_irq = combo_rise && !combo_reset_enable_i; // RULE15
	assign combo_rst = combo_rise && combo_reset_enable_i; // RULE15

	// ==========================================================
	// Key ordering
	// Only a two-key report can arrive out of scan order
	wire [ROW_W-1:0] lo_row;
	wire [COL_W-1:0] lo_col;
	wire [ROW_W-1:0] hi_row;
	wire [COL_W-1:0] hi_col;

	kws_key_order #(
		.ROW_W(ROW_W),
		.COL_W(COL_W)
	) u_order (
		.both_i(key_count_i == `KWS_CNT_TWO),
		.a_row_i(key_a_row_i),
		.a_col_i(key_a_col_i),
		.b_row_i(key_b_row_i),
		.b_col_i(key_b_col_i),
		.lo_row_o(lo_row),
		.lo_col_o(lo_col),
		.hi_row_o(hi_row),
		.hi_col_o(hi_col)
	);

	// ==========================================================
	// Status word assembly, reserved bits zero
	reg [31:0] st_word;

	always @* begin
		st_word = `KWS_ZERO32; // RULE16
		st_word[`KWS_ST_INT] = int_r;
		st_word[`KWS_ST_TRST] = trst_r;
		st_word[`KWS_ST_PDW] = pdw_r;
		st_word[`KWS_ST_TRIPLE_COMBO_SEEN] = combo_r;
		st_word[`KWS_ST_TWO_PRESSED_FLAG] = two_r;
		st_word[`KWS_ST_ONE_PRESSED_FLAG] = one_r;
		st_word[`KWS_ST_K1R_HI:`KWS_ST_K1R_LO] = k1_row_r;
		st_word[`KWS_ST_K1C_HI:`KWS_ST_K1C_LO] = k1_col_r;
		st_word[`KWS_ST_K0R_HI:`KWS_ST_K0R_LO] = k0_row_r;
		st_word[`KWS_ST_K0C_HI:`KWS_ST_K0C_LO] = k0_col_r;
	end

	assign status_word = st_word;

	// ==========================================================
	// Sticky flags: a set wins, a read clears only what it returned
	always @* begin
		int_nxt = int_r;
		trst_nxt = trst_r;
		pdw_nxt = pdw_r;
		combo_nxt = combo_r;
		if (rd_status) begin
			int_nxt = int_r && !prdata_r[`KWS_ST_INT]; // RULE7
			trst_nxt = trst_r && !prdata_r[`KWS_ST_TRST]; // RULE9
			pdw_nxt = pdw_r && !prdata_r[`KWS_ST_PDW];
			combo_nxt = combo_r && !prdata_r[`KWS_ST_TRIPLE_COMBO_SEEN];
		end
		// Sets follow the clears so an event on a read edge is kept
		if (key_change_i || combo_irq) begin
			int_nxt = 1'b1; // RULE5 RULE6
		end
		// Only the first edge out of reset records the three-key origin
		if (!boot_r && reset_by_combo_i) begin
			trst_nxt = 1'b1; // RULE8
		end
		if (wake_hit) begin
			pdw_nxt = 1'b1; // RULE10
		end
		if (combo_rise) begin
			combo_nxt = 1'b1; // RULE11
		end
	end

	// ==========================================================
	// APB slave: no wait states, data captured in the setup cycle
	// A flag set during the access waits for the next read
	always @(posedge clock_i) begin
		if (srst_i) begin
			prdata_r <= `KWS_ZERO32;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pready_r <= 1'b1;
			pslverr_r <= !(hit_cfg || hit_status);
			if (pwrite_i) begin
				prdata_r <= `KWS_ZERO32;
			end else if (hit_cfg) begin
				prdata_r <= cfg_r;
			end else if (hit_status) begin
				prdata_r <= status_word;
			end else begin
				prdata_r <= `KWS_ZERO32;
			end
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// ==========================================================
	// Wakeup configuration register
	always @(posedge clock_i) begin
		if (srst_i) begin
			cfg_r <= `KWS_CFG_RESET; // RULE12
		end else if (wr_cfg) begin
			cfg_r <= pwdata_i & `KWS_CFG_WMASK; // RULE16
		end
	end

	// ==========================================================
	// Status flags and key record
	always @(posedge clock_i) begin
		if (srst_i) begin
			int_r <= 1'b0; // RULE12
			trst_r <= 1'b0;
			pdw_r <= 1'b0;
			combo_r <= 1'b0;
			two_r <= 1'b0;
			one_r <= 1'b0;
			k0_row_r <= {ROW_W{1'b0}};
			k0_col_r <= {COL_W{1'b0}};
			k1_row_r <= {ROW_W{1'b0}};
			k1_col_r <= {COL_W{1'b0}};
			boot_r <= 1'b0;
			match_prev_r <= 1'b0;
		end else begin
			int_r <= int_nxt;
			trst_r <= trst_nxt;
			pdw_r <= pdw_nxt;
			combo_r <= combo_nxt;
			boot_r <= 1'b1;
			// Edge memory keeps a held combination from firing twice
			match_prev_r <= combo_detect_enable_i && combo_match_i;
			// Count flags and addresses follow the latest scan, not sticky
			if (scan_done_i) begin
				one_r <= (key_count_i == `KWS_CNT_ONE); // RULE14
				two_r <= (key_count_i == `KWS_CNT_TWO); // RULE14
				k0_row_r <= lo_row; // RULE13
				k0_col_r <= lo_col;
				k1_row_r <= hi_row;
				k1_col_r <= hi_col;
			end
		end
	end

	// ==========================================================
	// Registered side outputs
	always @(posedge clock_i) begin
		if (srst_i) begin
			irq_r <= 1'b0;
			rst_req_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			// The interrupt pin tracks the flag value that this edge stores
			irq_r <= int_nxt; // RULE5
			rst_req_r <= combo_rst; // RULE15
			wake_r <= wake_hit; // RULE1
		end
	end

	// ==========================================================
	// Output ports
	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign keypad_irq_o = irq_r;
	assign combo_reset_req_o = rst_req_r;
	assign wakeup_o = wake_r;

endmodule // kws_keypad_status

// file: logic/kws_consts.vh
// Register map, field positions and reset values of the keypad wakeup and status block.
// Assumes a 32-bit APB address space with byte addressing.
`ifndef KWS_CONSTS_VH
`define KWS_CONSTS_VH

// ==========================================================
// Register addresses
`define KWS_ADDR_WAKE_CFG 32'hFFF8_8008
`define KWS_ADDR_STATUS 32'hFFF8_800C

// ==========================================================
// Wakeup configuration fields
`define KWS_CFG_WAKE_EN 16
`define KWS_CFG_COL_HI 15
`define KWS_CFG_COL_LO 8
`define KWS_CFG_ROW_HI 3
`define KWS_CFG_ROW_LO 0
`define KWS_CFG_WMASK 32'h0001_FF0F
`define KWS_CFG_RESET 32'h0000_0000

// ==========================================================
// Status fields
`define KWS_ST_INT 21
`define KWS_ST_TRST 20
`define KWS_ST_PDW 19
`define KWS_ST_TRIPLE_COMBO_SEEN 18
`define KWS_ST_TWO_PRESSED_FLAG 17
`define KWS_ST_ONE_PRESSED_FLAG 16
`define KWS_ST_K1R_HI 14
`define KWS_ST_K1R_LO 11
`define KWS_ST_K1C_HI 10
`define KWS_ST_K1C_LO 8
`define KWS_ST_K0R_HI 6
`define KWS_ST_K0R_LO 3
`define KWS_ST_K0C_HI 2
`define KWS_ST_K0C_LO 0
`define KWS_ST_RESET 32'h0000_0000

// ==========================================================
// Key counts and the one-hot row limit without decoder
`define KWS_CNT_ONE 2'h1
`define KWS_CNT_TWO 2'h2
`define KWS_ONEHOT_ROWS 4'h4
`define KWS_ZERO32 32'h0000_0000

`endif

// file: logic/kws_key_order.v
// Orders two reported key addresses into scan order (row first, then column).
// Assumes key a is valid whenever any key is reported; b only when both_i is high.
`timescale 1ns/1ns

module kws_key_order #(
	parameter ROW_W = 4,
	parameter COL_W = 3
) (
	input wire both_i,
	input wire [ROW_W-1:0] a_row_i,
	input wire [COL_W-1:0] a_col_i,
	input wire [ROW_W-1:0] b_row_i,
	input wire [COL_W-1:0] b_col_i,
	output reg [ROW_W-1:0] lo_row_o,
	output reg [COL_W-1:0] lo_col_o,
	output reg [ROW_W-1:0] hi_row_o,
	output reg [COL_W-1:0] hi_col_o
);

	// ==========================================================
	// Compare packed scan addresses
	wire [ROW_W+COL_W-1:0] a_addr;
	wire [ROW_W+COL_W-1:0] b_addr;
	wire swap;

	assign a_addr = {a_row_i, a_col_i};
	assign b_addr = {b_row_i, b_col_i};
	assign swap = both_i && (b_addr < a_addr);

	always @* begin
		if (swap) begin
			lo_row_o = b_row_i; // RULE13
			lo_col_o = b_col_i;
			hi_row_o = a_row_i;
			hi_col_o = a_col_i;
		end else begin
			lo_row_o = a_row_i;
			lo_col_o = a_col_i;
			hi_row_o = b_row_i;
			hi_col_o = b_col_i;
		end
	end

endmodule // kws_key_order

// file: test/kws_matrix.sv
// Key switch matrix model: pressed columns of the probed row.
// Assumes the bench fills keys and drives the row index.
`timescale 1ns/1ns
module kws_matrix (
	input wire [3:0] probe_row_i,
	output wire [7:0] col_sense_o
);
	reg [7:0] keys [0:15];
	assign col_sense_o = keys[probe_row_i];
endmodule // kws_matrix

// file: test/kws_chk_assertions.sv
// Port checker of the keypad wakeup and status block.
// Assumes default widths; bound to every instance.
`timescale 1ns/1ns
`include "kws_consts.vh"
module kws_chk (
	input wire clock_i,
	input wire srst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [31:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire key_change_i,
	input wire combo_detect_enable_i,
	input wire combo_reset_enable_i,
	input wire combo_match_i,
	input wire powerdown_i,
	input wire decoder_mode_i,
	input wire [3:0] probe_row_i,
	input wire [7:0] col_sense_i,
	input wire keypad_irq_o,
	input wire combo_reset_req_o,
	input wire wakeup_o
);
	// ==========
	// Shadow of the wakeup configuration
	reg [31:0] cfg_r;
	wire acc = psel_i & penable_i & pready_o;
	wire wr_cfg = acc & pwrite_i & (paddr_i == `KWS_ADDR_WAKE_CFG);
	wire rd_st = acc & !pwrite_i & (paddr_i == `KWS_ADDR_STATUS);
	wire combo_on = combo_detect_enable_i & combo_match_i;
	wire row_hit = decoder_mode_i ? (cfg_r[3:0] == probe_row_i) : (probe_row_i < 4'h4 && cfg_r[probe_row_i[1:0]]);
	wire wake_c = powerdown_i & cfg_r[16] & row_hit & (|(cfg_r[15:8] & col_sense_i));
	always @(posedge clock_i) begin
		if (srst_i) begin
			cfg_r <= 32'h0000_0000;
		end else if (wr_cfg) begin
			cfg_r <= pwdata_i & `KWS_CFG_WMASK;
		end
	end
	// ==========
	// Properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	AST_WAKE_ON: assert property (wake_c |=> wakeup_o) else $error("no wakeup");
	AST_WAKE_OFF: assert property (!wake_c |=> !wakeup_o) else $error("false wakeup");
	AST_CHG_IRQ: assert property (key_change_i |-> ##[1:2] keypad_irq_o) else $error("no irq");
	AST_RD_CLR: assert property (!key_change_i && !combo_on ##1 rd_st && !key_change_i && !combo_on
		|=> !keypad_irq_o) else $error("irq kept");
	AST_COMBO_IRQ: assert property ($rose(combo_on) && !combo_reset_enable_i |-> ##[1:2] keypad_irq_o)
		else $error("no combo irq");
	AST_COMBO_RST: assert property ($rose(combo_on) && combo_reset_enable_i |-> ##[1:2] combo_reset_req_o)
		else $error("no reset req");
	AST_REQ_PULSE: assert property (combo_reset_req_o |=> !combo_reset_req_o) else $error("long req");
	AST_NO_COMBO: assert property (!combo_detect_enable_i [*3] |-> !combo_reset_req_o) else $error("stray req");
	cover property (wake_c);
	cover property ($rose(combo_on) && combo_reset_enable_i);
	cover property (rd_st);
endmodule // kws_chk

bind kws_keypad_status kws_chk u_chk (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.pready_o, .key_change_i, .combo_detect_enable_i, .combo_reset_enable_i, .combo_match_i, .powerdown_i,
	.decoder_mode_i, .probe_row_i, .col_sense_i, .keypad_irq_o, .combo_reset_req_o, .wakeup_o);

// file: test/test_keypad_wakeup_and_status.sv
// Self-checking bench of the keypad wakeup and status block.
// Assumes APB at 10 MHz and the matrix model on the column inputs.
`timescale 1ns/1ns
`include "kws_consts.vh"
module test_keypad_wakeup_and_status;
	reg clock_i, srst_i, psel_i, penable_i, pwrite_i, scan_done_i, key_change_i, powerdown_i, decoder_mode_i;
	reg combo_detect_enable_i, combo_reset_enable_i, combo_match_i, reset_by_combo_i, ev;
	reg [31:0] paddr_i, pwdata_i, rv;
	reg [1:0] key_count_i;
	reg [3:0] key_a_row_i, key_b_row_i, probe_row_i, n;
	reg [2:0] key_a_col_i, key_b_col_i;
	wire [31:0] prdata_o;
	wire [7:0] col_sense_i;
	wire pready_o, pslverr_o, keypad_irq_o, combo_reset_req_o, wakeup_o;
	int miscompares, check_count;
	kws_matrix pm (.probe_row_i, .col_sense_o(col_sense_i));
	kws_keypad_status uut (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .scan_done_i, .key_change_i, .key_count_i, .key_a_row_i, .key_a_col_i,
		.key_b_row_i, .key_b_col_i, .combo_detect_enable_i, .combo_reset_enable_i, .combo_match_i,
		.reset_by_combo_i, .powerdown_i, .decoder_mode_i, .probe_row_i, .col_sense_i, .keypad_irq_o,
		.combo_reset_req_o, .wakeup_o);
	// ==========
	// Shared tasks
	task chk(input reg [31:0] g, input reg [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input reg w, input reg [31:0] a, input reg [31:0] d);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'h1;
		@(posedge clock_i);
		while (pready_o !== 1'h1) @(posedge clock_i);
		rv = prdata_o;
		ev = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clock_i);
	endtask
	task scan(input reg [1:0] c, input reg [13:0] k);
		scan_done_i <= 1'h1;
		key_change_i <= 1'h1;
		key_count_i <= c;
		{key_a_row_i, key_a_col_i, key_b_row_i, key_b_col_i} <= k;
		@(posedge clock_i);
		scan_done_i <= 1'h0;
		key_change_i <= 1'h0;
		@(posedge clock_i);
	endtask
	task stop_test;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ==========
	// Scenarios
	task t_regs;
		apb(0, `KWS_ADDR_WAKE_CFG, 0);
		chk(rv, `KWS_CFG_RESET);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv, 32'h0010_0000);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv, `KWS_ST_RESET);
		apb(1, `KWS_ADDR_WAKE_CFG, 32'hFFFF_FFFF);
		apb(1, `KWS_ADDR_STATUS, 32'hFFFF_FFFF);
		apb(0, `KWS_ADDR_WAKE_CFG, 0);
		chk(rv, `KWS_CFG_WMASK);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv, `KWS_ST_RESET);
		apb(0, 32'hFFF8_8010, 0);
		chk({31'h0, ev}, 32'h1);
	endtask
	task t_scan;
		scan(2'h2, {4'h4, 3'h6, 4'h1, 3'h3});
		chk(keypad_irq_o, 1);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv, 32'h0022_260B);
		chk(keypad_irq_o, 0);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv, 32'h0002_260B);
		scan(2'h1, {4'h2, 3'h5, 4'h0, 3'h0});
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv & 32'h003F_007F, 32'h0021_0015);
	endtask
	task t_combo;
		combo_match_i <= 1'h1;
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv & 32'h0024_0000, 0);
		combo_match_i <= 1'h0;
		combo_detect_enable_i <= 1'h1;
		@(posedge clock_i);
		combo_match_i <= 1'h1;
		@(posedge clock_i);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv & 32'h0024_0000, 32'h0024_0000);
		combo_match_i <= 1'h0;
		combo_reset_enable_i <= 1'h1;
		@(posedge clock_i);
		combo_match_i <= 1'h1;
		n = 0;
		repeat (4) @(posedge clock_i) n = n + combo_reset_req_o;
		chk(n, 1);
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv & 32'h0024_0000, 32'h0004_0000);
		combo_match_i <= 1'h0;
	endtask
	task t_wake;
		pm.keys[3] <= 8'h20;
		probe_row_i <= 4'h3;
		decoder_mode_i <= 1'h1;
		apb(1, `KWS_ADDR_WAKE_CFG, 32'h0000_2503);
		powerdown_i <= 1'h1;
		repeat (3) @(posedge clock_i);
		chk(wakeup_o, 0);
		apb(1, `KWS_ADDR_WAKE_CFG, 32'h0001_2503);
		@(posedge clock_i);
		chk(wakeup_o, 1);
		pm.keys[3] <= 8'h02;
		repeat (3) @(posedge clock_i);
		chk(wakeup_o, 0);
		pm.keys[3] <= 8'h20;
		decoder_mode_i <= 1'h0;
		apb(1, `KWS_ADDR_WAKE_CFG, 32'h0001_2508);
		@(posedge clock_i);
		chk(wakeup_o, 1);
		powerdown_i <= 1'h0;
		apb(0, `KWS_ADDR_STATUS, 0);
		chk(rv & 32'h0008_0000, 32'h0008_0000);
		chk(wakeup_o, 0);
	endtask
	// ==========
	// Clock, reset, sequence and watchdog
	initial begin
		clock_i = 0;
		forever #50 clock_i = ~clock_i;
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		miscompares++;
		stop_test;
	end
	initial begin
		{psel_i, penable_i, pwrite_i, scan_done_i, key_change_i, powerdown_i, decoder_mode_i} = 0;
		{combo_detect_enable_i, combo_reset_enable_i, combo_match_i, paddr_i, pwdata_i, key_count_i} = 0;
		{key_a_row_i, key_b_row_i, probe_row_i, key_a_col_i, key_b_col_i} = 0;
		srst_i = 1'h1;
		reset_by_combo_i = 1'h1;
		for (int i = 0; i < 16; i++) pm.keys[i] = 8'h00;
		repeat (4) @(posedge clock_i);
		srst_i <= 1'h0;
		@(posedge clock_i);
		reset_by_combo_i <= 1'h0;
		t_regs;
		t_scan;
		t_combo;
		t_wake;
		stop_test;
	end
endmodule // test_keypad_wakeup_and_status
